// [dv/scrl_serial_peer.sv]
`timescale 1ns/1ps
module scrl_serial_peer #(
  parameter int BRG_P = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [2:0] tbe_lvl,
  input wire logic ev_go,
  input wire logic [1:0] ev_ch,
  input wire logic [2:0] ev_kind,
  output logic [2:0] tx_buf_empty,
  output logic [2:0] rx_done,
  output logic [2:0] rx_ovr,
  output logic [2:0] rx_par,
  output logic [2:0] rx_frm,
  output logic [2:0] brg_out
);
  logic [7:0] brg_cnt_ff;
  logic [2:0] hit;
  assign hit = ev_go ? (3'h1 << ev_ch) : 3'h0;
  initial begin
    {tx_buf_empty, rx_done, rx_ovr, rx_par, rx_frm, brg_out} = 18'h0;
    brg_cnt_ff = 8'h0;
  end
  // kinds: 0 clean frame, 1 overrun, 2 parity, 3 framing, 4 frame with parity
  always @(posedge mclk) begin
    if (sys_rst) begin
      {tx_buf_empty, rx_done, rx_ovr, rx_par, rx_frm, brg_out} <= 18'h0;
      brg_cnt_ff <= 8'h0;
    end else begin
      tx_buf_empty <= tbe_lvl;
      rx_done <= (ev_kind == 3'h0 || ev_kind == 3'h4) ? hit : 3'h0;
      rx_ovr <= (ev_kind == 3'h1) ? hit : 3'h0;
      rx_par <= (ev_kind == 3'h2 || ev_kind == 3'h4) ? hit : 3'h0;
      rx_frm <= (ev_kind == 3'h3) ? hit : 3'h0;
      // one divider pulse every BRG_P cycles, a sixteenth of mclk at the default BRG_P of 16
      brg_cnt_ff <= (brg_cnt_ff == 8'(BRG_P - 1)) ? 8'h0 : brg_cnt_ff + 8'h1;
      brg_out <= (brg_cnt_ff == 8'h0) ? 3'h7 : 3'h0;
    end
  end
endmodule : scrl_serial_peer

// [dv/test_serial_channel_request_logic.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_serial_channel_request_logic;
  import scrl_pkg::*;
  logic mclk, sys_rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic [23:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rng;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, sclk_out, sclk_oe, irq_tx, irq_rx;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq_grp2, ev_go;
  logic [2:0] tx_buf_empty, rx_done, rx_ovr, rx_par, rx_frm, brg_out;
  logic [2:0] brg_src_tick, tx_en, rx_en, fmt_sync, fmt_seven, fmt_nine;
  logic [2:0] par_en, par_even, two_stop, ext_clk_sel, tbe_lvl, ev_kind;
  logic [1:0] ev_ch;
  logic [7:0] dma_req;
  logic [33:0] exp_q[$];
  logic [33:0] w_exp;
  string name_q[$];
  string w_name;
  int compares, miscompares, cycles;
  logic [31:0] cnt;
  int tk[4] = '{256, 32, 8, 1};
  logic ps, pb;

  scrl_request_logic u_scrl_request_logic (.mclk, .sys_rst, .ce,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_buf_empty,
    .rx_done, .rx_ovr, .rx_par, .rx_frm, .brg_out, .brg_src_tick, .tx_en,
    .rx_en, .fmt_sync, .fmt_seven, .fmt_nine, .par_en, .par_even, .two_stop,
    .ext_clk_sel, .sclk_out, .sclk_oe, .irq_tx, .irq_rx, .irq_grp2, .dma_req);
  scrl_serial_peer u_scrl_serial_peer (.mclk, .sys_rst, .tbe_lvl, .ev_go,
    .ev_ch, .ev_kind, .tx_buf_empty, .rx_done, .rx_ovr, .rx_par, .rx_frm,
    .brg_out);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic close_out();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // bus results are checked in arrival order against the driver's notes
  always @(posedge mclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      w_name = name_q.pop_front();
      w_exp = exp_q.pop_front();
      `CHK(w_name, w_exp, s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata})
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic wr(input logic [23:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY, input bit go = 1'b0);
    bit ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    name_q.push_back("bresp");
    exp_q.push_back({er, 32'h0});
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ev_go <= go;
    while (!(ad && wd)) begin
      @(posedge mclk);
      ev_go <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input string n, input logic [23:0] a,
                    input logic [31:0] v, input logic [1:0] r = RESP_OKAY);
    name_q.push_back(n);
    exp_q.push_back({r, v});
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  // ends just after the edge at which the design sampled the pulse
  task automatic ev(input int c, input int k);
    @(posedge mclk);
    ev_ch <= 2'(c);
    ev_kind <= 3'(k);
    ev_go <= 1'b1;
    @(posedge mclk);
    ev_go <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : ev

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  initial begin
    {sys_rst, ce, s_axi_wstrb, rng} = {1'b1, 1'b1, 4'hF, 32'hEC81};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, ev_go, ev_ch, ev_kind, tbe_lvl} = 10'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 80'h0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rd("stat", OFS_STAT, 32'h0);
    rd("mask", OFS_MASK, 32'h0);
    rd("sel", OFS_SEL, 32'h0);
    rd("ctrl0", OFS_CTRL0, 32'h0);
    rd("unmapped", 24'h80011C, 32'h0, RESP_SLVERR);
    wr(24'h80011C, 32'hFFFFFFFF, RESP_SLVERR);
    wr(OFS_STAT, 32'hFFFFFFFF);
    rd("stat sw set", OFS_STAT, 32'h0);
    for (int f = 0; f < 8; f++) begin
      rng = xs(rng);
      wr(OFS_CTRL1, (rng & 32'hF80) | (f << C_FMT));
      settle(1);
      `CHK("sync", f[2], fmt_sync[1])
      `CHK("seven", f == 0, fmt_seven[1])
      `CHK("nine", f[2:1] == 2'b01, fmt_nine[1])
      `CHK("ext", f[2] & rng[C_CKS], ext_clk_sel[1])
      if (!f[2]) begin
        `CHK("par_en", rng[C_PEN], par_en[1])
        `CHK("par_even", rng[C_PSEL], par_even[1])
        `CHK("two_stop", rng[C_STB], two_stop[1])
      end
    end
    wr(OFS_CTRL2, 32'h4 << C_FMT);
    settle(1);
    `CHK("ch2 sync", 1'b0, fmt_sync[2])
    @(posedge mclk);
    tbe_lvl <= 3'h7;
    settle(2);
    `CHK("dma idle", 8'h00, dma_req)
    for (int c = 0; c < 3; c++) wr(OFS_CTRL0 + 24'(4 * c), 32'h1);
    settle(2);
    `CHK("irq_tx masked", 2'b00, irq_tx)
    `CHK("tx_en", 3'h7, tx_en)
    `CHK("rx_en off", 3'h0, rx_en)
    `CHK("dma tx", 8'hC8, dma_req)
    `CHK("grp masked", 1'b0, irq_grp2)
    rd("stat tx2", OFS_STAT, 32'h10);
    wr(OFS_MASK, 32'h3F);
    settle(1);
    `CHK("irq_tx", 2'b11, irq_tx)
    `CHK("grp", 1'b1, irq_grp2)
    @(posedge mclk);
    tbe_lvl <= 3'h0;
    settle(3);
    `CHK("irq_tx full", 2'b00, irq_tx)
    `CHK("dma tx full", 8'h00, dma_req)
    for (int c = 0; c < 3; c++) wr(OFS_CTRL0 + 24'(4 * c), 32'h2);
    wr(OFS_STAT, 32'hEF);
    rd("stat clr4", OFS_STAT, 32'h0);
    `CHK("rx_en on", 3'h7, rx_en)
    @(posedge mclk);
    ev_ch <= 2'h2;
    ev_kind <= 3'h0;
    wr(OFS_STAT, 32'hDF, RESP_OKAY, 1'b1);
    rd("stat set wins", OFS_STAT, 32'h20);
    wr(OFS_STAT, 32'hEF);
    rd("stat keep", OFS_STAT, 32'h20);
    wr(OFS_MASK, 32'h0);
    ev(0, 0);
    `CHK("irq_rx masked", 1'b0, irq_rx[0])
    `CHK("dma rx unmasked", 1'b1, dma_req[DMA_RX0])
    wr(OFS_CTRL1, 32'h0);
    ev(1, 0);
    `CHK("dma rx off", 1'b0, dma_req[DMA_RX1])
    wr(OFS_CTRL1, 32'h2);
    wr(OFS_MASK, 32'h3F);
    for (int s = 0; s < 2; s++) begin
      wr(OFS_SEL, s ? 32'h30 : 32'h0);
      for (int c = 0; c < 2; c++) begin
        for (int k = 0; k < 5; k++) begin
          ev(c, k);
          `CHK("irq_rx", s ? k != 0 : k != 1, irq_rx[c])
          `CHK("dma_rx", k == 0, dma_req[c ? DMA_RX1 : DMA_RX0])
          settle(1);
          `CHK("irq_rx end", 1'b0, irq_rx[c])
        end
      end
    end
    wr(OFS_CTRL1, 32'h2 | (32'h4 << C_FMT));
    wr(OFS_ERR, 32'h0);
    ev(1, 2);
    ev(0, 3);
    rd("err", OFS_ERR, 32'hC);
    wr(OFS_SEL, 32'h40);
    wr(OFS_STAT, 32'hDF);
    ev(2, 0);
    `CHK("dma rx2", 1'b1, dma_req[DMA_RX2])
    rd("stat ch2 done", OFS_STAT, 32'h0);
    ev(2, 1);
    `CHK("dma rx2 err", 1'b0, dma_req[DMA_RX2])
    settle(1);
    `CHK("grp rx", 1'b1, irq_grp2)
    rd("stat ch2 ovr", OFS_STAT, 32'h20);
    for (int dv = 0; dv < 4; dv++) begin
      wr(OFS_CTRL2, 32'(dv) << C_DIV);
      settle(2);
      cnt = 0;
      repeat (256) begin
        @(posedge mclk);
        #1;
        cnt += 32'(brg_src_tick[2]);
      end
      `CHK("ticks", tk[dv], cnt)
    end
    wr(OFS_CTRL0, (32'h1 << C_FIX) | (32'h1 << C_FMT));
    settle(1);
    `CHK("sclk_oe", 1'b1, sclk_oe[0])
    repeat (40) begin
      ps = sclk_out[0];
      pb = brg_out[0];
      settle(1);
      `CHK("sclk", ps ^ pb, sclk_out[0])
    end
    wr(OFS_CTRL0, (32'h1 << C_FIX) | (32'h4 << C_FMT));
    settle(1);
    `CHK("sclk_oe sync", 1'b0, sclk_oe[0])
    close_out();
  end
endmodule : test_serial_channel_request_logic

// [rtl/scrl_pkg.sv]
package scrl_pkg;
  localparam int NCH = 3;
  localparam logic [23:0] OFS_STAT = 24'h800100;
  localparam logic [23:0] OFS_MASK = 24'h800104;
  localparam logic [23:0] OFS_SEL = 24'h800108;
  localparam logic [23:0] OFS_CTRL0 = 24'h80010C;
  localparam logic [23:0] OFS_CTRL1 = 24'h800110;
  localparam logic [23:0] OFS_CTRL2 = 24'h800114;
  localparam logic [23:0] OFS_ERR = 24'h800118;
  localparam int ST_TX2 = 4;
  localparam int ST_RX2 = 5;
  localparam int SEL_B0 = 4;
  localparam int C_TXEN = 0;
  localparam int C_RXEN = 1;
  localparam int C_DIV = 2;
  localparam int C_FMT = 4;
  localparam int C_CKS = 7;
  localparam int C_STB = 8;
  localparam int C_PSEL = 9;
  localparam int C_PEN = 10;
  localparam int C_FIX = 11;
  localparam int CTRL_W = 12;
  localparam int E_OVR = 0;
  localparam int E_PAR = 1;
  localparam int E_FRM = 2;
  localparam int E_SUM = 3;
  localparam int E_W = 4;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_8 = 2'h1;
  localparam logic [1:0] DIV_32 = 2'h2;
  localparam logic [7:0] PS_M8 = 8'h07;
  localparam logic [7:0] PS_M32 = 8'h1F;
  localparam logic [7:0] PS_M256 = 8'hFF;
  localparam int DMA_N = 8;
  localparam int DMA_TX0 = 3;
  localparam int DMA_RX0 = 4;
  localparam int DMA_TX1 = 6;
  localparam int DMA_RX1 = 3;
  localparam int DMA_TX2 = 7;
  localparam int DMA_RX2 = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : scrl_pkg

// [rtl/scrl_request_logic.sv]
`timescale 1ns/1ps
module scrl_request_logic
  import scrl_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] tx_buf_empty,
  input wire logic [2:0] rx_done,
  input wire logic [2:0] rx_ovr,
  input wire logic [2:0] rx_par,
  input wire logic [2:0] rx_frm,
  input wire logic [2:0] brg_out,
  output logic [2:0] brg_src_tick,
  output logic [2:0] tx_en,
  output logic [2:0] rx_en,
  output logic [2:0] fmt_sync,
  output logic [2:0] fmt_seven,
  output logic [2:0] fmt_nine,
  output logic [2:0] par_en,
  output logic [2:0] par_even,
  output logic [2:0] two_stop,
  output logic [2:0] ext_clk_sel,
  output logic [1:0] sclk_out,
  output logic [1:0] sclk_oe,
  output logic [1:0] irq_tx,
  output logic [1:0] irq_rx,
  output logic irq_grp2,
  output logic [DMA_N-1:0] dma_req
);

  if (ADDR_W < 24) begin : g_chk
    $error("ADDR_W must hold the 24-bit register offsets");
  end

  // bus slave state
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, wdata_ff;
  logic [3:0] wstrb_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  // register file
  logic [7:0] stat_ff, sel_ff;
  logic [5:0] mask_ff;
  logic [CTRL_W-1:0] ctrl_ff [0:NCH-1];
  logic [NCH*E_W-1:0] err_ff;
  logic [7:0] ps_ff;
  logic tx2_q_ff;
  // registered outputs
  logic [2:0] tick_ff, txen_ff, rxen_ff, sync_ff, seven_ff, nine_ff;
  logic [2:0] pen_ff, peven_ff, stb_ff, cks_ff;
  logic [1:0] sclk_ff, sclk_oe_ff, irq_tx_ff, irq_rx_ff;
  logic irq_grp_ff;
  logic [DMA_N-1:0] dma_ff;

  // write happens once both address and data are held; the answer comes
  // one edge after the later half, so bvalid never precedes the update
  wire wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
  wire ar_fire = s_axi_arvalid && arready_ff;
  wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                       {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [31:0] wbits = wdata_ff & wmask;
  wire w_stat = wr_fire && awaddr_ff == ADDR_W'(OFS_STAT);
  wire w_mask = wr_fire && awaddr_ff == ADDR_W'(OFS_MASK);
  wire w_sel = wr_fire && awaddr_ff == ADDR_W'(OFS_SEL);
  wire w_err = wr_fire && awaddr_ff == ADDR_W'(OFS_ERR);
  wire [2:0] w_ctrl;
  assign w_ctrl[0] = wr_fire && awaddr_ff == ADDR_W'(OFS_CTRL0);
  assign w_ctrl[1] = wr_fire && awaddr_ff == ADDR_W'(OFS_CTRL1);
  assign w_ctrl[2] = wr_fire && awaddr_ff == ADDR_W'(OFS_CTRL2);
  wire w_hit = w_stat || w_mask || w_sel || w_err || (|w_ctrl);

  wire r_stat = s_axi_araddr == ADDR_W'(OFS_STAT);
  wire r_mask = s_axi_araddr == ADDR_W'(OFS_MASK);
  wire r_sel = s_axi_araddr == ADDR_W'(OFS_SEL);
  wire r_err = s_axi_araddr == ADDR_W'(OFS_ERR);
  wire r_c0 = s_axi_araddr == ADDR_W'(OFS_CTRL0);
  wire r_c1 = s_axi_araddr == ADDR_W'(OFS_CTRL1);
  wire r_c2 = s_axi_araddr == ADDR_W'(OFS_CTRL2);
  wire r_hit = r_stat || r_mask || r_sel || r_err || r_c0 || r_c1 || r_c2;
  wire [31:0] rd_word =
    r_stat ? {24'h000000, stat_ff} :
    r_mask ? {26'h0000000, mask_ff} :
    r_sel ? {24'h000000, sel_ff} :
    r_err ? {20'h00000, err_ff} :
    r_c0 ? {20'h00000, ctrl_ff[0]} :
    r_c1 ? {20'h00000, ctrl_ff[1]} :
    r_c2 ? {20'h00000, ctrl_ff[2]} : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_ff) begin
        awaddr_ff <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        wready_ff <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // read data are latched at the address handshake and held for rready
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_word;
        rresp_ff <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // per-channel request logic
  logic [2:0] tx_req, rx_req, txi_w, rxi_w, dtx_w, drx_w, tick_w;
  logic [2:0] sync_w, fix_w;
  logic [NCH*E_W-1:0] err_set;
  logic [NCH*E_W-1:0] err_keep;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire [CTRL_W-1:0] cr = ctrl_ff[c];
    wire [1:0] div = cr[C_DIV+1:C_DIV];
    // channel two has no synchronous mode
    assign sync_w[c] = (c < 2) && cr[C_FMT+2];
    wire par_c = rx_par[c] && !sync_w[c];
    wire frm_c = rx_frm[c] && !sync_w[c];
    wire any_c = rx_ovr[c] || par_c || frm_c;
    wire cause = sel_ff[SEL_B0+c] ? any_c
                 : (rx_done[c] || par_c || frm_c);
    // tx and rx are gated separately, so either may run alone
    assign tx_req[c] = cr[C_TXEN] && tx_buf_empty[c];
    assign rx_req[c] = cr[C_RXEN] && cause;
    assign txi_w[c] = tx_req[c] && mask_ff[2*c];
    assign rxi_w[c] = rx_req[c] && mask_ff[2*c+1];
    assign dtx_w[c] = tx_req[c];
    assign drx_w[c] = cr[C_RXEN] && rx_done[c] && !any_c;
    assign tick_w[c] = div == DIV_1 ? 1'b1 :
      div == DIV_8 ? (ps_ff[2:0] == PS_M8[2:0]) :
      div == DIV_32 ? (ps_ff[4:0] == PS_M32[4:0]) : (ps_ff == PS_M256);
    assign fix_w[c] = (c < 2) && cr[C_FIX] && !sync_w[c] && !cr[C_CKS];
    assign err_set[c*E_W+E_OVR] = rx_ovr[c];
    assign err_set[c*E_W+E_PAR] = par_c;
    assign err_set[c*E_W+E_FRM] = frm_c;
    assign err_set[c*E_W+E_SUM] = any_c && !sync_w[c];

    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        ctrl_ff[c] <= CTRL_RST;
      end else if (ce && w_ctrl[c]) begin
        ctrl_ff[c] <= (ctrl_ff[c] & ~wmask[CTRL_W-1:0])
                      | wbits[CTRL_W-1:0];
      end
    end
  end

  // error flags clear like the group status: a written 0 clears
  assign err_keep = w_err ? wdata_ff[NCH*E_W-1:0] | ~wmask[NCH*E_W-1:0]
                    : '1;
  wire [7:0] stat_keep = w_stat ? (wdata_ff[7:0] | ~wmask[7:0])
                         : 8'hFF;
  wire [7:0] stat_set;
  assign stat_set[ST_TX2] = tx_req[2] && !tx2_q_ff;
  assign stat_set[ST_RX2] = rx_req[2];
  assign stat_set[3:0] = 4'h0;
  assign stat_set[7:6] = 2'h0;
  // set wins against a clear in the same cycle
  wire [7:0] nxt_stat = (stat_ff & stat_keep) | stat_set;
  wire grp_w = (stat_ff[ST_TX2] && mask_ff[4])
               || (stat_ff[ST_RX2] && mask_ff[5]);
  logic [DMA_N-1:0] dma_w;
  // input channel 3 is shared by two sources, so it is an or of both
  always_comb begin
    dma_w = '0;
    dma_w[DMA_TX0] = dtx_w[0];
    dma_w[DMA_RX0] = drx_w[0];
    dma_w[DMA_TX1] = dtx_w[1];
    dma_w[DMA_RX1] = dma_w[DMA_RX1] | drx_w[1];
    dma_w[DMA_TX2] = dtx_w[2];
    dma_w[DMA_RX2] = drx_w[2];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stat_ff <= STAT_RST;
      mask_ff <= MASK_RST;
      sel_ff <= SEL_RST;
      err_ff <= '0;
      tx2_q_ff <= 1'b0;
      ps_ff <= 8'h00;
    end else if (ce) begin
      stat_ff <= nxt_stat & 8'h30;
      if (w_mask) begin
        mask_ff <= (mask_ff & ~wmask[5:0]) | wbits[5:0];
      end
      if (w_sel) begin
        sel_ff <= ((sel_ff & ~wmask[7:0]) | wbits[7:0]) & 8'h70;
      end
      err_ff <= (err_ff & err_keep) | err_set;
      tx2_q_ff <= tx_req[2];
      // one free prescaler serves all channels; each picks its own carry
      ps_ff <= ps_ff + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_tx_ff <= 2'h0;
      irq_rx_ff <= 2'h0;
      irq_grp_ff <= 1'b0;
      dma_ff <= '0;
      tick_ff <= 3'h0;
      sclk_ff <= 2'h0;
      sclk_oe_ff <= 2'h0;
    end else if (ce) begin
      irq_tx_ff <= txi_w[1:0];
      irq_rx_ff <= rxi_w[1:0];
      irq_grp_ff <= grp_w;
      dma_ff <= dma_w;
      tick_ff <= tick_w;
      sclk_oe_ff <= fix_w[1:0];
      // toggling on each divider pulse halves its rate
      for (int i = 0; i < 2; i++) begin
        sclk_ff[i] <= fix_w[i] && (sclk_ff[i] ^ brg_out[i]);
      end
    end
  end

  // format decode seen by the framing logic
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      txen_ff <= 3'h0;
      rxen_ff <= 3'h0;
      sync_ff <= 3'h0;
      seven_ff <= 3'h0;
      nine_ff <= 3'h0;
      pen_ff <= 3'h0;
      peven_ff <= 3'h0;
      stb_ff <= 3'h0;
      cks_ff <= 3'h0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        txen_ff[i] <= ctrl_ff[i][C_TXEN];
        rxen_ff[i] <= ctrl_ff[i][C_RXEN];
        sync_ff[i] <= sync_w[i];
        seven_ff[i] <= !sync_w[i]
                       && ctrl_ff[i][C_FMT+:3] == 3'h0;
        nine_ff[i] <= !sync_w[i] && ctrl_ff[i][C_FMT+1];
        pen_ff[i] <= !sync_w[i] && ctrl_ff[i][C_PEN];
        peven_ff[i] <= ctrl_ff[i][C_PSEL];
        stb_ff[i] <= !sync_w[i] && ctrl_ff[i][C_STB];
        // external clock only means something in sync mode
        cks_ff[i] <= sync_w[i] && ctrl_ff[i][C_CKS];
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign brg_src_tick = tick_ff;
  assign tx_en = txen_ff;
  assign rx_en = rxen_ff;
  assign fmt_sync = sync_ff;
  assign fmt_seven = seven_ff;
  assign fmt_nine = nine_ff;
  assign par_en = pen_ff;
  assign par_even = peven_ff;
  assign two_stop = stb_ff;
  assign ext_clk_sel = cks_ff;
  assign sclk_out = sclk_ff;
  assign sclk_oe = sclk_oe_ff;
  assign irq_tx = irq_tx_ff;
  assign irq_rx = irq_rx_ff;
  assign irq_grp2 = irq_grp_ff;
  assign dma_req = dma_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_tx_dma_level: assert property (
    ce |=> dma_req[DMA_TX2] == $past(tx_buf_empty[2] && ctrl_ff[2][C_TXEN]))
    else $error("tx dma request does not follow empty and enable");
  a_rx_dma_noerr: assert property (
    ce && rx_ovr[0] |=> !dma_req[DMA_RX0])
    else $error("rx dma request raised on a receive error");
  a_tx_irq_mask: assert property (
    ce && !mask_ff[0] |=> !irq_tx[0])
    else $error("masked tx interrupt passed");
  a_tx_irq_enable: assert property (
    ce && tx_buf_empty[1] && mask_ff[2] && ctrl_ff[1][C_TXEN] |=> irq_tx[1])
    else $error("tx interrupt missing after enable");
  a_stat_set_wins: assert property (
    ce && rx_req[2] && w_stat |=> stat_ff[ST_RX2])
    else $error("status clear beat a hardware set");
  a_stat_write_one: assert property (
    ce && w_stat && wdata_ff[ST_TX2] && stat_ff[ST_TX2] |=> stat_ff[ST_TX2])
    else $error("writing one changed a status bit");
  a_grp_irq_or: assert property (
    ce |=> irq_grp2 == $past(|(stat_ff[5:4] & mask_ff[5:4])))
    else $error("group interrupt not gated status");
  a_rx_cause_err: assert property (
    ce && sel_ff[SEL_B0] && !rx_ovr[0] && !rx_par[0] && !rx_frm[0]
    |=> !irq_rx[0])
    else $error("error-only cause fired without error");
  a_ch2_async: assert property (
    ce && ctrl_ff[2][C_FMT+2] |=> !fmt_sync[2] && !ext_clk_sel[2])
    else $error("channel two left asynchronous framing");
  a_stat_rx_set: assert property (
    ce && rx_req[2] |=> stat_ff[ST_RX2])
    else $error("group receive status not set by request");
  a_err_sum_frm: assert property (
    ce && rx_frm[1] && !sync_w[1] |=> err_ff[E_W+E_SUM])
    else $error("framing error did not raise error sum");
  a_fixclk_half: assert property (
    ce && fix_w[0] && brg_out[0] |=> sclk_out[0] != $past(sclk_out[0]))
    else $error("fixed clock did not toggle on divider pulse");
  c_tx_irq: cover property (ce && irq_tx[0] ##1 !irq_tx[0]);
  c_rx_dma: cover property (dma_req[DMA_RX2]);
  c_grp_irq: cover property (stat_set[ST_RX2] && w_stat);
  c_fix_clk: cover property (sclk_oe[0] && sclk_out[0]);
  c_err_sum: cover property (err_ff[E_SUM]);

endmodule : scrl_request_logic
